// >>> rtl/cpw_array.sv
// counter array with six pwm capture/compare modules and their registers
`timescale 1ns/10ps

//Contract
//R01 - pwm frequency follows shared counter timebase
//R02 - 8-bit duty set by compare low byte
//R03 - 8-bit: low byte match drives pin high
//R04 - 8-bit: low byte overflow drives pin low
//R05 - low byte wrap reloads compare low from high
//R06 - 8-bit mode: enable, pwm set, wide clear
//R07 - software writes compare low byte first
//R08 - compare low write clears comparator enable
//R09 - compare high write sets comparator enable
//R10 - 16-bit value sets output low time
//R11 - 16-bit: match high, overflow low
//R12 - 16-bit mode: enable, pwm, wide all set
//R13 - software times duty updates to match irq
//R14 - software enables match interrupt for updates
//R15 - counter wrap sets sticky overflow flag
//R16 - match flag cleared only by software
//R17 - three-bit select picks counter timebase
//R18 - counter advances only while run set
//R19 - compare match sets flag, requests interrupt
module cpw_array (
    input  wire logic                           ref_clk,
    input  wire logic                           rstn,
    input  wire cpw_pkg::cpw_sfr_req_type       sfr_req,
    output logic [7:0]                          sfr_rdata,
    input  wire logic                           timer0_overflow,
    input  wire logic                           external_count_input,
    input  wire logic                           ext_osc_in,
    output logic [cpw_pkg::NUM_MODULES-1:0]     module_output_pin,
    output logic                                irq_request
);

    // number of capture/compare modules sharing the counter
    localparam int N = cpw_pkg::NUM_MODULES;

    // shared counter and control state
    logic [15:0]  count_q;
    logic [15:0]  count_next;
    logic         counter_run_q;
    logic         counter_overflow_flag_q;
    logic         ovf_irq_en_q;
    logic [2:0]   timebase_select_q;

    // per module flags and their interrupt enables
    logic [N-1:0] module_match_flag_q;
    logic [N-1:0] match_set;
    logic [N-1:0] irq_en_bits;

    // per module mode and compare registers
    logic [7:0]   mode_q    [N];
    logic [7:0]   cmp_lo_q  [N];
    logic [7:0]   cmp_hi_q  [N];

    // timebase sources after synchronising
    logic [3:0]   prescale_q;
    logic [2:0]   eci_sync_q;
    logic [2:0]   osc_sync_q;
    logic [2:0]   osc_div_q;
    logic         osc_tick;
    logic         eci_fall;
    logic         base_tick;

    // counter events of this cycle
    logic         tick;
    logic         low_wrap;
    logic         full_wrap;

    // decoded register writes
    logic         wr_ctrl;
    logic         wr_array_mode;
    logic         wr_cnt_lo;
    logic         wr_cnt_hi;
    logic         cnt_sw_wr;

    // shared register writes decoded once here; module registers decode their own below
    assign wr_ctrl   = sfr_req.wr && (sfr_req.addr == cpw_pkg::ADDR_CTRL_STATUS);
    assign wr_cnt_lo = sfr_req.wr && (sfr_req.addr == cpw_pkg::ADDR_CNT_LO);
    assign wr_cnt_hi = sfr_req.wr && (sfr_req.addr == cpw_pkg::ADDR_CNT_HI);
    assign wr_array_mode = sfr_req.wr && (sfr_req.addr == cpw_pkg::ADDR_ARRAY_MODE);
    assign cnt_sw_wr     = wr_cnt_lo || wr_cnt_hi;

    // shared mod-12 prescaler; the /4 taps come out evenly spaced from it
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            prescale_q <= 4'h0;
        end else if (prescale_q == cpw_pkg::PRESCALE_LAST) begin
            prescale_q <= 4'h0;
        end else begin
            prescale_q <= prescale_q + 4'h1;
        end
    end

    // pin inputs: two flops, then a third stage only for edge detection
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            eci_sync_q <= 3'h0;
            osc_sync_q <= 3'h0;
        end else begin
            eci_sync_q <= {eci_sync_q[1:0], external_count_input};
            osc_sync_q <= {osc_sync_q[1:0], ext_osc_in};
        end
    end

    // edges taken between the second and third stages only
    assign eci_fall = eci_sync_q[2] && !eci_sync_q[1];
    assign osc_tick = osc_sync_q[1] && !osc_sync_q[2] && (osc_div_q == cpw_pkg::EIGHTH_LAST);

    // external oscillator divided by 8 after synchronising; limited to sys/2
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            osc_div_q <= 3'h0;
        end else if (osc_sync_q[1] && !osc_sync_q[2]) begin
            osc_div_q <= osc_div_q + 3'h1;
        end
    end

    // timebase selection; reserved codes give no counter clock
    always_comb begin
        unique case (timebase_select_q) // [R17]
            cpw_pkg::TB_SYS_DIV12: base_tick = (prescale_q == cpw_pkg::PRESCALE_LAST);
            cpw_pkg::TB_SYS_DIV4:  base_tick = (prescale_q[1:0] == cpw_pkg::QUARTER_LAST);
            cpw_pkg::TB_TIMER0:    base_tick = timer0_overflow;
            cpw_pkg::TB_EXT_FALL:  base_tick = eci_fall;
            cpw_pkg::TB_SYS:       base_tick = 1'b1;
            cpw_pkg::TB_EXT_DIV8:  base_tick = osc_tick;
            default:               base_tick = 1'b0;
        endcase
    end

    // a software counter write swallows the tick, so no match or wrap fires on a skipped count
    assign tick       = base_tick && counter_run_q && !cnt_sw_wr; // [R18]
    assign count_next = count_q + 16'h0001;
    assign low_wrap   = tick && (count_q[7:0] == cpw_pkg::LOW_MAX);
    assign full_wrap  = tick && (count_q == cpw_pkg::COUNT_MAX);

    // shared counter; a software write beats a tick in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            count_q <= cpw_pkg::COUNT_RESET;
        end else if (wr_cnt_lo) begin
            count_q[7:0] <= sfr_req.wdata;
        end else if (wr_cnt_hi) begin
            count_q[15:8] <= sfr_req.wdata;
        end else if (tick) begin
            count_q <= count_next; // [R01]
        end
    end

    // control/status: hardware set wins over a software clear
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            counter_run_q           <= 1'b0;
            counter_overflow_flag_q <= 1'b0;
            module_match_flag_q     <= '0;
        end else begin
            if (wr_ctrl) begin
                counter_run_q <= sfr_req.wdata[cpw_pkg::CS_RUN_BIT];
            end
            // sticky flags: only a software write takes them down
            counter_overflow_flag_q <= full_wrap // [R15]
                || (wr_ctrl ? sfr_req.wdata[cpw_pkg::CS_OVF_BIT] : counter_overflow_flag_q);
            module_match_flag_q <= match_set // [R16] [R19]
                | (wr_ctrl ? sfr_req.wdata[N-1:0] : module_match_flag_q);
        end
    end

    // array mode register: timebase and overflow interrupt enable
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            timebase_select_q <= 3'h0;
            ovf_irq_en_q      <= 1'b0;
        end else if (wr_array_mode) begin
            timebase_select_q <= sfr_req.wdata[cpw_pkg::AM_TB_MSB:cpw_pkg::AM_TB_LSB]; // [R17]
            ovf_irq_en_q      <= sfr_req.wdata[cpw_pkg::AM_OVF_IRQ_EN_BIT];
        end
    end

    // one pwm channel per module
    for (genvar m = 0; m < N; m++) begin : g_mod
        // register addresses, mode decode and compare terms of this module
        logic [7:0]  mode_addr;
        logic [7:0]  lo_addr;
        logic [7:0]  hi_addr;
        logic        ecom;
        logic        pwm8;
        logic        pwm16;
        logic [7:0]  lo_eff;
        logic        match8;
        logic        match16;

        // each module sits at its base address plus its index
        assign mode_addr = cpw_pkg::ADDR_MODE_BASE + 8'(m);
        assign lo_addr   = cpw_pkg::ADDR_CMP_LO_BASE + 8'(m);
        assign hi_addr   = cpw_pkg::ADDR_CMP_HI_BASE + 8'(m);
        assign ecom      = mode_q[m][cpw_pkg::MD_ECOM_BIT];
        assign pwm8      = ecom && mode_q[m][cpw_pkg::MD_PWM_BIT] && !mode_q[m][cpw_pkg::MD_WIDE_BIT]; // [R06]
        assign pwm16     = ecom && mode_q[m][cpw_pkg::MD_PWM_BIT] && mode_q[m][cpw_pkg::MD_WIDE_BIT]; // [R12]
        // at the wrap the fresh reload is what the new low byte meets
        assign lo_eff    = low_wrap ? cmp_hi_q[m] : cmp_lo_q[m];
        assign match8    = tick && (count_next[7:0] == lo_eff); // [R02]
        assign match16   = tick && (count_next == {cmp_hi_q[m], cmp_lo_q[m]}); // [R10]

        // flag request and interrupt enable of this module
        assign match_set[m]   = (pwm8 && match8) || (pwm16 && match16); // [R19]
        assign irq_en_bits[m] = mode_q[m][cpw_pkg::MD_IRQEN_BIT];

        // mode register; compare byte writes steer the enable bit
        always_ff @(posedge ref_clk) begin
            if (!rstn) begin
                mode_q[m] <= cpw_pkg::RESET_BYTE;
            end else if (sfr_req.wr && (sfr_req.addr == mode_addr)) begin
                mode_q[m] <= sfr_req.wdata;
            end else if (sfr_req.wr && (sfr_req.addr == lo_addr)) begin
                mode_q[m][cpw_pkg::MD_ECOM_BIT] <= 1'b0; // [R08] [R07]
            end else if (sfr_req.wr && (sfr_req.addr == hi_addr)) begin
                mode_q[m][cpw_pkg::MD_ECOM_BIT] <= 1'b1; // [R09]
            end
        end

        // compare bytes; the 8-bit reload overrides nothing software wrote
        always_ff @(posedge ref_clk) begin
            if (!rstn) begin
                cmp_lo_q[m] <= cpw_pkg::RESET_BYTE;
                cmp_hi_q[m] <= cpw_pkg::RESET_BYTE;
            end else begin
                if (sfr_req.wr && (sfr_req.addr == lo_addr)) begin
                    cmp_lo_q[m] <= sfr_req.wdata;
                end else if (pwm8 && low_wrap) begin
                    cmp_lo_q[m] <= cmp_hi_q[m]; // [R05]
                end
                // high byte changes only by software
                if (sfr_req.wr && (sfr_req.addr == hi_addr)) begin
                    cmp_hi_q[m] <= sfr_req.wdata;
                end
            end
        end

        // pin: match drives high and wins over the overflow low
        always_ff @(posedge ref_clk) begin
            if (!rstn) begin
                module_output_pin[m] <= 1'b0;
            end else if (pwm8) begin
                if (match8) begin
                    module_output_pin[m] <= 1'b1; // [R03]
                end else if (low_wrap) begin
                    module_output_pin[m] <= 1'b0; // [R04]
                end
            end else if (pwm16) begin
                if (match16) begin
                    module_output_pin[m] <= 1'b1; // [R11]
                end else if (full_wrap) begin
                    module_output_pin[m] <= 1'b0; // [R11]
                end
            end else begin
                module_output_pin[m] <= 1'b0; // other modes are not built here
            end
        end
    end

    // interrupt request, registered so it comes straight from a flop
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            irq_request <= 1'b0;
        end else begin
            irq_request <= (|(module_match_flag_q & irq_en_bits)) // [R19]
                || (counter_overflow_flag_q && ovf_irq_en_q);
        end
    end

    // read data, one cycle after the read strobe; unmapped reads zero
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sfr_rdata <= cpw_pkg::RESET_BYTE;
        end else if (sfr_req.rd) begin
            sfr_rdata <= cpw_pkg::RESET_BYTE;
            if (sfr_req.addr == cpw_pkg::ADDR_CTRL_STATUS) begin
                sfr_rdata <= {counter_overflow_flag_q, counter_run_q, module_match_flag_q};
            end else if (sfr_req.addr == cpw_pkg::ADDR_ARRAY_MODE) begin
                sfr_rdata <= {4'h0, timebase_select_q, ovf_irq_en_q};
            end else if (sfr_req.addr == cpw_pkg::ADDR_CNT_LO) begin
                sfr_rdata <= count_q[7:0];
            end else if (sfr_req.addr == cpw_pkg::ADDR_CNT_HI) begin
                sfr_rdata <= count_q[15:8];
            end
            // per module registers, matched by base plus index
            for (int k = 0; k < N; k++) begin
                if (sfr_req.addr == cpw_pkg::ADDR_MODE_BASE + 8'(k)) begin
                    sfr_rdata <= mode_q[k];
                end
                if (sfr_req.addr == cpw_pkg::ADDR_CMP_LO_BASE + 8'(k)) begin
                    sfr_rdata <= cmp_lo_q[k];
                end
                if (sfr_req.addr == cpw_pkg::ADDR_CMP_HI_BASE + 8'(k)) begin
                    sfr_rdata <= cmp_hi_q[k];
                end
            end
        end
    end

endmodule

// >>> rtl/cpw_pkg.sv
// constants, register map and carrier types for the counter array pwm block
package cpw_pkg;

    localparam int NUM_MODULES = 6;

    // special function register addresses
    localparam logic [7:0] ADDR_CTRL_STATUS = 8'hD8;
    localparam logic [7:0] ADDR_ARRAY_MODE  = 8'hD9;
    localparam logic [7:0] ADDR_MODE_BASE   = 8'hDA;
    localparam logic [7:0] ADDR_CMP_LO_BASE = 8'hE0;
    localparam logic [7:0] ADDR_CNT_LO      = 8'hE8;
    localparam logic [7:0] ADDR_CMP_HI_BASE = 8'hF0;
    localparam logic [7:0] ADDR_CNT_HI      = 8'hF8;

    // array_control_status fields
    localparam int CS_OVF_BIT = 7;
    localparam int CS_RUN_BIT = 6;

    // array mode register fields
    localparam int AM_OVF_IRQ_EN_BIT = 0;
    localparam int AM_TB_LSB         = 1;
    localparam int AM_TB_MSB         = 3;

    // module_mode_reg fields
    localparam int MD_WIDE_BIT  = 7;
    localparam int MD_ECOM_BIT  = 6;
    localparam int MD_PWM_BIT   = 1;
    localparam int MD_IRQEN_BIT = 0;

    localparam logic [7:0]  RESET_BYTE  = 8'h00;
    localparam logic [7:0]  LOW_MAX     = 8'hFF;
    localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // timebase dividers
    localparam logic [3:0] PRESCALE_LAST = 4'hB;
    localparam logic [1:0] QUARTER_LAST  = 2'h3;
    localparam logic [2:0] EIGHTH_LAST   = 3'h7;

    typedef enum logic [2:0] {
        TB_SYS_DIV12 = 3'h0,
        TB_SYS_DIV4  = 3'h1,
        TB_TIMER0    = 3'h2,
        TB_EXT_FALL  = 3'h3,
        TB_SYS       = 3'h4,
        TB_EXT_DIV8  = 3'h5
    } cpw_timebase_type;

    // one register access from the core
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } cpw_sfr_req_type;

endpackage

// >>> sim/cpw_load.sv
// pwm load model: times the high pulses seen on one module pin
`timescale 1ns/10ps
module cpw_load (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        level,
    output logic [16:0]      high_len
);
    logic [16:0] run_len_q;

    // a falling pin closes a pulse; only whole pulses are published
    always_ff @(posedge ref_clk) begin
        if (!rstn || !level) begin
            run_len_q <= 17'h00000;
        end else begin
            run_len_q <= run_len_q + 17'h00001;
        end
        if (!rstn) begin
            high_len <= 17'h00000;
        end else if (!level && run_len_q != 17'h00000) begin
            high_len <= run_len_q;
        end
    end
endmodule

// >>> sim/cpw_array_sva.sv
// assertion checker for the counter array pwm block
`timescale 1ns/10ps
module cpw_array_sva (
    input wire logic                             ref_clk,
    input wire logic                             rstn,
    input wire cpw_pkg::cpw_sfr_req_type         sfr_req,
    input wire logic [7:0]                       sfr_rdata,
    input wire logic                             timer0_overflow,
    input wire logic                             external_count_input,
    input wire logic                             ext_osc_in,
    input wire logic [cpw_pkg::NUM_MODULES-1:0]  module_output_pin,
    input wire logic                             irq_request
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic       run_q;
    logic [2:0] tb_q;
    logic [7:0] md0_q;

    // shadow of run, timebase and module 0 mode, mirrored from bus writes
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            run_q <= 1'b0;
            tb_q  <= 3'h0;
            md0_q <= 8'h00;
        end else if (sfr_req.wr) begin
            if (sfr_req.addr == cpw_pkg::ADDR_CTRL_STATUS) run_q <= sfr_req.wdata[cpw_pkg::CS_RUN_BIT];
            if (sfr_req.addr == cpw_pkg::ADDR_ARRAY_MODE) tb_q <= sfr_req.wdata[cpw_pkg::AM_TB_MSB:cpw_pkg::AM_TB_LSB];
            if (sfr_req.addr == cpw_pkg::ADDR_MODE_BASE) md0_q <= sfr_req.wdata;
            if (sfr_req.addr == cpw_pkg::ADDR_CMP_LO_BASE) md0_q[cpw_pkg::MD_ECOM_BIT] <= 1'b0;
            if (sfr_req.addr == cpw_pkg::ADDR_CMP_HI_BASE) md0_q[cpw_pkg::MD_ECOM_BIT] <= 1'b1;
        end
    end

    sequence rd_pair(logic [7:0] ad);
        (sfr_req.rd && !sfr_req.wr && sfr_req.addr == ad) [*2];
    endsequence
    sequence wr_then_mode(logic [7:0] ad);
        (sfr_req.wr && sfr_req.addr == ad) ##2 (sfr_req.rd && sfr_req.addr == cpw_pkg::ADDR_MODE_BASE);
    endsequence

    lo_clears_en_a: assert property (wr_then_mode(cpw_pkg::ADDR_CMP_LO_BASE) |=> !sfr_rdata[6])
        else $error("compare low write left enable set");
    hi_sets_en_a: assert property (wr_then_mode(cpw_pkg::ADDR_CMP_HI_BASE) |=> sfr_rdata[6])
        else $error("compare high write left enable clear");
    ovf_sticky_a: assert property (rd_pair(cpw_pkg::ADDR_CTRL_STATUS) |=> !($past(sfr_rdata[7]) && !sfr_rdata[7]))
        else $error("overflow flag dropped without a write");
    match_sticky_a: assert property (rd_pair(cpw_pkg::ADDR_CTRL_STATUS) |=> ($past(sfr_rdata) & ~sfr_rdata & 8'h3F) == 8'h00)
        else $error("match flag dropped without a write");
    run_hold_a: assert property (!run_q ##0 rd_pair(cpw_pkg::ADDR_CNT_LO) |=> $stable(sfr_rdata))
        else $error("counter moved while stopped");
    sys_tick_a: assert property (run_q && tb_q == 3'h4 ##0 rd_pair(cpw_pkg::ADDR_CNT_LO) |=> sfr_rdata == $past(sfr_rdata) + 8'h01)
        else $error("system clock timebase did not step by one");
    pin_off_a: assert property ((!(md0_q[6] && md0_q[1])) [*2] |-> !module_output_pin[0])
        else $error("pin high outside pwm mode");
    rdata_hold_a: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
        else $error("read data changed without a read");
endmodule

bind cpw_array cpw_array_sva chk (.ref_clk(ref_clk), .rstn(rstn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .timer0_overflow(timer0_overflow), .external_count_input(external_count_input), .ext_osc_in(ext_osc_in),
    .module_output_pin(module_output_pin), .irq_request(irq_request));

// >>> sim/cpw_array_tb.sv
// self-checking bench for the counter array pwm block
`timescale 1ns/10ps
module cpw_array_tb;
    logic                            ref_clk, rstn, t0, ecnt, eosc, irq;
    cpw_pkg::cpw_sfr_req_type        req;
    logic [7:0]                      rdata, a, b, d, dl;
    logic [7:0]                      tbexp [0:6];
    logic [cpw_pkg::NUM_MODULES-1:0] pins;
    logic [16:0]                     high_len, high_len5;
    int                              n_errors, n_compared;

    cpw_array dut (.ref_clk(ref_clk), .rstn(rstn), .sfr_req(req), .sfr_rdata(rdata), .timer0_overflow(t0),
        .external_count_input(ecnt), .ext_osc_in(eosc), .module_output_pin(pins), .irq_request(irq));
    cpw_load load (.ref_clk(ref_clk), .rstn(rstn), .level(pins[0]), .high_len(high_len));
    cpw_load load5 (.ref_clk(ref_clk), .rstn(rstn), .level(pins[5]), .high_len(high_len5));

    // free running 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // bus tasks leave one idle edge so strobes never toggle twice at once
    task automatic wr(input logic [7:0] ad, input logic [7:0] v);
        req.addr = ad;
        req.wdata = v;
        req.wr = 1'b1;
        @(negedge ref_clk);
        req.wr = 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] ad, input int n, output logic [7:0] d0, output logic [7:0] d1);
        req.addr = ad;
        req.rd = 1'b1;
        @(negedge ref_clk);
        d0 = rdata;
        if (n > 1) @(negedge ref_clk);
        d1 = rdata;
        req.rd = 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // hang guard, far beyond the few thousand cycles the tests take
    initial begin
        #500000;
        n_errors++;
        print_verdict();
    end

    initial begin
        void'($urandom(27406));
        tbexp = '{8'h08, 8'h18, 8'h0A, 8'h0A, 8'h60, 8'h02, 8'h00};
        req = '0;
        {t0, eosc} = 2'h0;
        ecnt = 1'b1;
        n_errors = 0;
        n_compared = 0;
        rstn = 1'b0;
        repeat (5) @(negedge ref_clk);
        rstn = 1'b1;
        rd(cpw_pkg::ADDR_CTRL_STATUS, 1, a, b);
        chk("ctrl_status", 17'h00000, {9'h000, a});
        wr(cpw_pkg::ADDR_CNT_LO, 8'h5A);
        rd(cpw_pkg::ADDR_CNT_LO, 2, a, b);
        chk("stopped", 17'h0005A, {9'h000, b});
        // each timebase over 96 edges, with pulses and edges fed meanwhile
        for (int c = 0; c < 7; c++) begin
            wr(cpw_pkg::ADDR_ARRAY_MODE, {4'h0, c[2:0], 1'b0});
            wr(cpw_pkg::ADDR_CTRL_STATUS, 8'h40);
            rd(cpw_pkg::ADDR_CNT_LO, 1, a, b);
            for (int i = 0; i < 94; i++) begin
                t0 = (c == 2) && (i % 8 == 1) && (i < 80);
                ecnt = !((c == 3) && (i < 80) && (i % 8 >= 4));
                eosc = (c == 5) && (i < 64) && (i % 4 >= 2);
                @(negedge ref_clk);
            end
            rd(cpw_pkg::ADDR_CNT_LO, 1, b, d);
            dl = b - a;
            chk("ticks", {9'h000, tbexp[c]}, {9'h000, dl});
            wr(cpw_pkg::ADDR_CTRL_STATUS, 8'h00);
        end
        wr(cpw_pkg::ADDR_ARRAY_MODE, 8'h08);
        wr(cpw_pkg::ADDR_CTRL_STATUS, 8'h40);
        rd(cpw_pkg::ADDR_CNT_LO, 2, a, b);
        chk("step", {9'h000, a + 8'h01}, {9'h000, b});
        // 8-bit pwm: corner duties then random ones, low byte first
        for (int k = 0; k < 5; k++) begin
            d = (k == 0) ? 8'h01 : (k == 1) ? 8'hFF : 8'($urandom_range(254, 1));
            wr(cpw_pkg::ADDR_MODE_BASE, 8'h42);
            wr(cpw_pkg::ADDR_CMP_LO_BASE, ~d);
            rd(cpw_pkg::ADDR_MODE_BASE, 1, a, b);
            chk("lo_clears", 17'h00002, {9'h000, a});
            wr(cpw_pkg::ADDR_CMP_HI_BASE, d);
            rd(cpw_pkg::ADDR_MODE_BASE, 1, a, b);
            chk("hi_sets", 17'h00042, {9'h000, a});
            // module 5 runs the same duty so the top pin is timed too
            wr(cpw_pkg::ADDR_MODE_BASE + 8'h05, 8'h42);
            wr(cpw_pkg::ADDR_CMP_LO_BASE + 8'h05, ~d);
            wr(cpw_pkg::ADDR_CMP_HI_BASE + 8'h05, d);
            repeat (600) @(negedge ref_clk);
            chk("high8", 17'h00100 - {9'h000, d}, high_len);
            chk("high8_m5", 17'h00100 - {9'h000, d}, high_len5);
            rd(cpw_pkg::ADDR_CMP_LO_BASE, 1, a, b);
            chk("reload", {9'h000, d}, {9'h000, a});
        end
        // 16-bit pwm near the wrap, match interrupt enabled; module 5 off before the flag clear
        wr(cpw_pkg::ADDR_MODE_BASE + 8'h05, 8'h00);
        wr(cpw_pkg::ADDR_CTRL_STATUS, 8'h00);
        wr(cpw_pkg::ADDR_MODE_BASE, 8'hC3);
        wr(cpw_pkg::ADDR_CMP_LO_BASE, 8'hF0);
        wr(cpw_pkg::ADDR_CMP_HI_BASE, 8'hFF);
        wr(cpw_pkg::ADDR_CNT_HI, 8'hFF);
        wr(cpw_pkg::ADDR_CNT_LO, 8'h00);
        wr(cpw_pkg::ADDR_CTRL_STATUS, 8'h40);
        repeat (300) @(negedge ref_clk);
        chk("high16", 17'h00010, high_len);
        rd(cpw_pkg::ADDR_CTRL_STATUS, 2, a, b);
        chk("flags", 17'h000C1, {9'h000, a});
        chk("flags_kept", 17'h000C1, {9'h000, b});
        chk("irq_on", 17'h00001, {16'h0000, irq});
        wr(cpw_pkg::ADDR_CTRL_STATUS, 8'h40);
        @(negedge ref_clk);
        chk("irq_off", 17'h00000, {16'h0000, irq});
        chk("pins_idle", 17'h00000, {13'h0000, pins[4:1]});
        print_verdict();
    end
endmodule
